// *** pmr_pkg.sv ***
// Package: offsets, field positions, reset values and carriers for the block
package pmr_pkg;
	localparam int NPH = 3;
	localparam int AW = 10;
	// Per-phase offsets, index 0 = phase A, 1 = B, 2 = C
	localparam logic [NPH-1:0][AW-1:0] EN_OFS = {10'h31d, 10'h231, 10'h145};
	localparam logic [NPH-1:0][AW-1:0] WRAP_OFS = {10'h31e, 10'h232, 10'h146};
	localparam logic [NPH-1:0][AW-1:0] PF_OFS = {10'h39e, 10'h2b2, 10'h1c6};
	localparam logic [NPH-1:0][AW-1:0] VRMS_OFS = {10'h3a0, 10'h2b4, 10'h1c8};
	localparam logic [NPH-1:0][AW-1:0] IRMS_OFS = {10'h3a4, 10'h2b8, 10'h1cc};
	localparam logic [AW-1:0] POS_ENERGY_C_OFS = 10'h3c0;
	localparam int POS_ENERGY_C_PHASE = 2;
	// Enable register fields
	localparam int EXCESS_CURRENT_BIT = 0;
	localparam int HIGH_VOLTAGE_BIT = 1;
	localparam int LOW_VOLTAGE_BIT = 2;
	localparam int MISSING_ZERO_CROSS_BIT = 3;
	localparam int POWER_REVERSAL_BIT = 4;
	localparam int DIRECTION_BIT = 6;
	localparam int NCOND = 5;
	localparam logic [7:0] EN_RESET = 8'h00;
	// Wrap flag fields
	localparam int POSITIVE_ENERGY_WRAP = 0;
	localparam int NEGATIVE_ENERGY_WRAP = 1;
	localparam int APPARENT_ENERGY_WRAP = 4;
	localparam logic [7:0] WRAP_RESET = 8'h00;
	localparam logic [15:0] PF_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	localparam logic [15:0] FREQ_RESET = 16'h0000;

	typedef struct packed {
		logic signed [31:0] instRealPower;
		logic [31:0] apparentPower;
		logic [31:0] rawVoltageRms;
		logic [31:0] rawCurrentRms;
		logic signed [15:0] powerFactorValue;
		logic overCurrent;
		logic overVoltage;
		logic underVoltage;
		logic noZeroCross;
	} pmrPhaseIn_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wrData;
	} pmrRegReq_t;
endpackage

// *** pmr_phase_metering_result_regs.sv ***
// Per-phase metering result, event enable and energy wrap registers
`timescale 1ns/1ns
`default_nettype none
module pmr_phase_metering_result_regs (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic dspTick,
	input wire pmr_pkg::pmrPhaseIn_t [pmr_pkg::NPH-1:0] phaseIn,
	input wire logic [15:0] lineFreqIn,
	input wire pmr_pkg::pmrRegReq_t regReq,
	input wire logic [pmr_pkg::NPH*pmr_pkg::NCOND-1:0] condClear,
	input wire logic [pmr_pkg::NCOND-1:0] summaryClear,
	input wire logic irqEnable,
	output logic [31:0] rdData,
	output logic rdValid,
	output logic [pmr_pkg::NCOND-1:0] summaryIrq,
	output logic irqReq,
	output logic [15:0] lineFreq,
	output logic [pmr_pkg::NPH*pmr_pkg::NCOND-1:0] conditionFlags
);
	localparam int NPH = pmr_pkg::NPH;
	localparam int NCOND = pmr_pkg::NCOND;

	logic [NPH-1:0][NCOND-1:0] gated;
	logic [NPH-1:0][31:0] phaseRd;
	logic [NPH-1:0] phaseHit;
	logic [NCOND-1:0] summary_q;
	logic [NCOND-1:0] summary_d;
	logic [31:0] rdData_q;
	logic rdValid_q;
	logic irqReq_q;
	logic [15:0] lineFreq_q;
	logic [31:0] rdMux;

	genvar p;
	for (p = 0; p < NPH; p++) begin : gPhase
		logic [7:0] enable_q;
		logic [7:0] wrap_q;
		logic [NCOND-1:0] cond_q;
		logic dirNeg_q;
		logic [31:0] posEnergy_q;
		logic [31:0] negEnergy_q;
		logic [31:0] appEnergy_q;
		logic [31:0] vrms_q;
		logic [31:0] irms_q;
		logic [15:0] pf_q;
		wire logic signed [31:0] act = phaseIn[p].instRealPower;
		wire logic actPos = !act[31] && (act != 32'h00000000);
		wire logic actNeg = act[31];
		wire logic [31:0] actMag = 32'(-act);
		wire logic [32:0] posSum = {1'b0, posEnergy_q} + {1'b0, act};
		wire logic [32:0] negSum = {1'b0, negEnergy_q} + {1'b0, actMag};
		wire logic [32:0] appSum =
			{1'b0, appEnergy_q} + {1'b0, phaseIn[p].apparentPower};
		wire logic posWrap = dspTick && actPos && posSum[32];
		wire logic negWrap = dspTick && actNeg && negSum[32];
		wire logic appWrap = dspTick && appSum[32];
		wire logic dirChange = dspTick && (actNeg != dirNeg_q);
		wire logic enWr = regReq.wr && (regReq.addr == pmr_pkg::EN_OFS[p]);
		wire logic wrapWr =
			regReq.wr && (regReq.addr == pmr_pkg::WRAP_OFS[p]);
		wire logic [7:0] wrapSet = {3'b000, appWrap, 2'b00, negWrap, posWrap};
		// Writing zero clears a wrap flag; a wrap in the same cycle still wins
		wire logic [7:0] wrapKeep = wrapWr ? regReq.wrData : 8'hff;
		wire logic [NCOND-1:0] condSet = {
			dirChange, phaseIn[p].noZeroCross, phaseIn[p].underVoltage,
			phaseIn[p].overVoltage, phaseIn[p].overCurrent};
		wire logic [NCOND-1:0] condClr = condClear[p*NCOND +: NCOND];
		wire logic [7:0] enRead = {1'b0, dirNeg_q, 1'b0, enable_q[4:0]};

		assign gated[p] = cond_q & enable_q[NCOND-1:0];
		assign phaseHit[p] = regReq.addr == pmr_pkg::EN_OFS[p]
			|| regReq.addr == pmr_pkg::WRAP_OFS[p]
			|| regReq.addr == pmr_pkg::PF_OFS[p]
			|| regReq.addr == pmr_pkg::VRMS_OFS[p]
			|| regReq.addr == pmr_pkg::IRMS_OFS[p]
			|| (p == pmr_pkg::POS_ENERGY_C_PHASE
			&& regReq.addr == pmr_pkg::POS_ENERGY_C_OFS);
		assign phaseRd[p] =
			(regReq.addr == pmr_pkg::EN_OFS[p]) ? {24'h000000, enRead} :
			(regReq.addr == pmr_pkg::WRAP_OFS[p]) ? {24'h000000, wrap_q} :
			(regReq.addr == pmr_pkg::PF_OFS[p]) ? {16'h0000, pf_q} :
			(regReq.addr == pmr_pkg::VRMS_OFS[p]) ? vrms_q :
			(regReq.addr == pmr_pkg::IRMS_OFS[p]) ? irms_q :
			(p == pmr_pkg::POS_ENERGY_C_PHASE
			&& regReq.addr == pmr_pkg::POS_ENERGY_C_OFS) ? posEnergy_q :
			32'h00000000;

		always_ff @(posedge ref_clk) begin
			if (srst) begin
				enable_q <= pmr_pkg::EN_RESET;
				wrap_q <= pmr_pkg::WRAP_RESET;
				cond_q <= '0;
				dirNeg_q <= 1'b0;
				posEnergy_q <= pmr_pkg::WORD_RESET;
				negEnergy_q <= pmr_pkg::WORD_RESET;
				appEnergy_q <= pmr_pkg::WORD_RESET;
				vrms_q <= pmr_pkg::WORD_RESET;
				irms_q <= pmr_pkg::WORD_RESET;
				pf_q <= pmr_pkg::PF_RESET;
			end else begin
				// Only the five gate bits are writable; direction is read-only
				if (enWr) begin
					enable_q <= {3'b000, regReq.wrData[4:0]};
				end
				wrap_q <= (wrap_q & wrapKeep) | wrapSet;
				cond_q <= (cond_q & ~condClr) | condSet;
				if (dspTick) begin
					dirNeg_q <= actNeg;
					vrms_q <= phaseIn[p].rawVoltageRms;
					irms_q <= phaseIn[p].rawCurrentRms;
					pf_q <= phaseIn[p].powerFactorValue;
					appEnergy_q <= appSum[31:0];
					if (actPos) begin
						posEnergy_q <= posSum[31:0];
					end
					if (actNeg) begin
						negEnergy_q <= negSum[31:0];
					end
				end
			end
		end
	end

	assign rdMux = phaseRd[0] | phaseRd[1] | phaseRd[2];
	// Hardware set wins over a clear arriving in the same cycle
	assign summary_d = (summary_q & ~summaryClear)
		| gated[0] | gated[1] | gated[2];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			summary_q <= '0;
			irqReq_q <= 1'b0;
			rdData_q <= pmr_pkg::WORD_RESET;
			rdValid_q <= 1'b0;
			lineFreq_q <= pmr_pkg::FREQ_RESET;
		end else begin
			summary_q <= summary_d;
			irqReq_q <= irqEnable && (|summary_d);
			rdValid_q <= regReq.rd;
			// Unmapped addresses read back as zero
			if (regReq.rd) begin
				rdData_q <= (|phaseHit) ? rdMux : 32'h00000000;
			end
			if (dspTick) begin
				lineFreq_q <= lineFreqIn;
			end
		end
	end

	assign rdData = rdData_q;
	assign rdValid = rdValid_q;
	assign summaryIrq = summary_q;
	assign irqReq = irqReq_q;
	assign lineFreq = lineFreq_q;
	assign conditionFlags = {gPhase[2].cond_q, gPhase[1].cond_q,
		gPhase[0].cond_q};
endmodule // pmr_phase_metering_result_regs
`default_nettype wire

// *** pmr_asserts.sv ***
// Concurrent checks on the metering result register block ports
`timescale 1ns/1ns
`default_nettype none
module pmr_asserts (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic dspTick,
	input wire pmr_pkg::pmrPhaseIn_t [pmr_pkg::NPH-1:0] phaseIn,
	input wire logic [15:0] lineFreqIn,
	input wire logic [pmr_pkg::NPH*pmr_pkg::NCOND-1:0] condClear,
	input wire logic irqEnable,
	input wire logic [pmr_pkg::NCOND-1:0] summaryIrq,
	input wire logic irqReq,
	input wire logic [15:0] lineFreq,
	input wire logic [pmr_pkg::NPH*pmr_pkg::NCOND-1:0] conditionFlags
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_irq_raise: assert property ($past(irqEnable) && |summaryIrq |-> irqReq)
		else $error("interrupt request not raised");
	a_irq_quiet: assert property (!$past(irqEnable) |-> !irqReq)
		else $error("interrupt request while disabled");
	a_flag_sticky: assert property ((~conditionFlags & $past(conditionFlags)
		& ~$past(condClear)) == '0) else $error("condition flag dropped");
	a_oc_flag: assert property (phaseIn[0].overCurrent |=> conditionFlags[0])
		else $error("overcurrent flag not set");
	a_ov_flag: assert property (phaseIn[1].overVoltage |=> conditionFlags[6])
		else $error("overvoltage flag not set");
	a_uv_flag: assert property (phaseIn[2].underVoltage |=> conditionFlags[12])
		else $error("undervoltage flag not set");
	a_oc_cause: assert property ($rose(summaryIrq[0])
		|-> |($past(conditionFlags) & 15'h0421)) else $error("summary without flag");
	a_freq_latch: assert property (dspTick |=> lineFreq == $past(lineFreqIn))
		else $error("line frequency not latched");
	c_irq: cover property (irqReq);
	c_rev: cover property (conditionFlags[14]);
	c_neg: cover property (dspTick && phaseIn[2].instRealPower < 0);
endmodule // pmr_asserts
bind pmr_phase_metering_result_regs pmr_asserts u_pmr_asserts (.ref_clk, .srst,
	.dspTick, .phaseIn, .lineFreqIn, .condClear, .irqEnable, .summaryIrq,
	.irqReq, .lineFreq, .conditionFlags);
`default_nettype wire

// *** pmr_host_model.sv ***
// Host model issuing single register reads and writes
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model (
	input wire logic ref_clk,
	input wire logic rdValid,
	input wire logic [31:0] rdData,
	output var pmr_pkg::pmrRegReq_t regReq
);
	initial regReq = '0;
	// A missing answer returns unknowns so the caller's compare fails
	task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge ref_clk) #1;
		regReq = '{addr: a, wr: w, rd: !w, wrData: d};
		@(posedge ref_clk) #1;
		// rdValid stands only in the cycle after the request edge; rdData holds until the next read
		q = rdValid ? rdData : 'x;
		regReq = '0;
	endtask
endmodule // pmr_host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the metering result register block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic ref_clk = 0, srst = 1, dspTick = 0, irqEnable = 1, rdValid, irqReq;
	pmr_pkg::pmrPhaseIn_t [2:0] phaseIn = '0;
	pmr_pkg::pmrRegReq_t regReq;
	logic [15:0] lineFreqIn = 16'h0000, lineFreq;
	logic [14:0] condClear = '0, conditionFlags;
	logic [4:0] summaryClear = '0, summaryIrq;
	logic [31:0] rdData, q, old;
	int error_cnt = 0, n_compared = 0;
	always #2 ref_clk = ~ref_clk;
	pmr_phase_metering_result_regs u_pmr_phase_metering_result_regs (.ref_clk,
		.srst, .dspTick, .phaseIn, .lineFreqIn, .regReq, .condClear, .summaryClear,
		.irqEnable, .rdData, .rdValid, .summaryIrq, .irqReq, .lineFreq, .conditionFlags);
	pmr_host_model u_pmr_host_model (.ref_clk, .rdValid, .rdData, .regReq);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		u_pmr_host_model.xfer(a, 1'b0, 8'h00, q);
		chk(q, exp);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		u_pmr_host_model.xfer(a, 1'b1, d, old);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk) #1 dspTick = 1;
			@(posedge ref_clk) #1 dspTick = 0;
		end
	endtask
	task automatic test_reset;
		for (int p = 0; p < 3; p++) begin
			rd(pmr_pkg::EN_OFS[p], 32'h0);
			rd(pmr_pkg::WRAP_OFS[p], 32'h0);
		end
	endtask
	task automatic test_results;
		phaseIn[0].rawVoltageRms = 32'h0012_3456;
		phaseIn[0].rawCurrentRms = 32'h0000_abcd;
		phaseIn[0].powerFactorValue = 16'shc000;
		lineFreqIn = 16'hc350;
		tick(1);
		rd(pmr_pkg::VRMS_OFS[0], 32'h0012_3456);
		rd(pmr_pkg::IRMS_OFS[0], 32'h0000_abcd);
		rd(pmr_pkg::PF_OFS[0], 32'h0000_c000);
		chk(32'(lineFreq), 32'h0000_c350);
	endtask
	task automatic test_energy;
		phaseIn[2].instRealPower = 32'sh7fff_ffff;
		phaseIn[2].apparentPower = 32'h8000_0000;
		tick(2);
		rd(pmr_pkg::POS_ENERGY_C_OFS, 32'hffff_fffe);
		old = q;
		tick(1);
		rd(pmr_pkg::POS_ENERGY_C_OFS, 32'h7fff_fffd);
		chk(32'(33'h1_0000_0000 + q - old), 32'h7fff_ffff);
		rd(pmr_pkg::WRAP_OFS[2], 32'h11);
		phaseIn[2].instRealPower = 32'sh8000_0001;
		phaseIn[2].apparentPower = 32'h0;
		tick(3);
		rd(pmr_pkg::WRAP_OFS[2], 32'h13);
		rd(pmr_pkg::POS_ENERGY_C_OFS, 32'h7fff_fffd);
		wr(pmr_pkg::EN_OFS[2], 8'h00);
		rd(pmr_pkg::EN_OFS[2], 32'h40);
		chk(32'(conditionFlags[14]), 32'h1);
		wr(pmr_pkg::WRAP_OFS[2], 8'h01);
		rd(pmr_pkg::WRAP_OFS[2], 32'h01);
	endtask
	task automatic test_irq;
		wr(pmr_pkg::EN_OFS[0], 8'h01);
		wr(pmr_pkg::EN_OFS[1], 8'h08);
		@(posedge ref_clk) #1 {phaseIn[0].overCurrent, phaseIn[1].overVoltage} = 2'b11;
		phaseIn[2].underVoltage = 1;
		phaseIn[1].noZeroCross = 1;
		@(posedge ref_clk) #1 {phaseIn[0].overCurrent, phaseIn[1].overVoltage} = 2'b00;
		phaseIn[2].underVoltage = 0;
		phaseIn[1].noZeroCross = 0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(32'(summaryIrq), 32'h09);
		chk(32'(irqReq), 32'h1);
		@(posedge ref_clk) #1 irqEnable = 0;
		condClear = 15'h1149;
		@(posedge ref_clk) #1 condClear = '0;
		summaryClear = 5'h09;
		@(posedge ref_clk) #1 summaryClear = '0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'({summaryIrq, irqReq}), 32'h0);
	endtask
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 srst = 0;
		test_reset;
		test_results;
		test_energy;
		test_irq;
		stop_test;
	end
endmodule // tb
`default_nettype wire
